// *** design/abr_pkg.sv ***
// constants, register map and state type of the autobaud rate detector
package abr_pkg;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_CMD = 8'h04;
	localparam logic [7:0] OFF_SYNC = 8'h08;
	localparam logic [7:0] OFF_TABLE = 8'h0C;
	localparam logic [7:0] OFF_MATCH = 8'h10;
	localparam logic [7:0] OFF_BUFPTR = 8'h14;
	localparam logic [7:0] OFF_CTLCHAR = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_EVENT = 8'h20;
	localparam logic [7:0] OFF_MASK = 8'h24;
	localparam logic [7:0] OFF_NOMSTART = 8'h28;
	localparam logic [7:0] OFF_MAXBIT = 8'h2C;
	localparam logic [7:0] OFF_LASTPTR = 8'h30;
	localparam logic [7:0] OFF_TBLDATA = 8'h34;
	localparam logic [7:0] OFF_TBLADDR = 8'h38;
	localparam int CTRL_RXEN = 0;
	localparam int CTRL_TXEN = 1;
	localparam int CTRL_LOOP = 2;
	localparam logic [1:0] LOOP_ECHO = 2'h2;
	localparam logic [15:0] SYNC_START = 16'h7FFF;
	localparam logic [15:0] SYNC_ECHO = 16'hFFFF;
	localparam int CMD_OPC = 5;
	localparam logic [1:0] CMD_HUNT = 2'h3;
	localparam int CMD_CH_W = 5;
	localparam int EV_TX = 1;
	localparam int EV_CTLCHAR = 3;
	localparam int ST_M1 = 0;
	localparam int ST_M2 = 1;
	localparam int ST_FRAME = 2;
	localparam int TBL_NOM = 0;
	localparam int TBL_MAX = 16;
	localparam int CHAR_BITS = 8;
	localparam int TX_BITS = 10;
	localparam logic [31:0] RST_ZERO = 32'h0000_0000;
	typedef enum logic [2:0] {
		ABR_IDLE, ABR_FETCH, ABR_LATCH, ABR_ARM, ABR_HUNT, ABR_START, ABR_ASSEMBLE, ABR_CHECK
	} abr_state_t;
endpackage

// *** design/abr_tbl_if.sv ***
// table read port between the detector and its lookup memory
`timescale 1ns/1ps
interface abr_tbl_if #(parameter int AW = 8);
	logic [AW-1:0] addr;
	logic [15:0] maxLen;
	logic [15:0] nomLen;
	modport user(output addr, input maxLen, input nomLen);
	modport mem(input addr, output maxLen, output nomLen);
endinterface

// *** design/abr_table_mem.sv ***
// lookup table memory with registered read data
`timescale 1ns/1ps
module abr_table_mem #(
	parameter int AW = 8
) (
	input wire logic clock,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [31:0] wdata,
	abr_tbl_if.mem tbl
);
	logic [31:0] mem [0:(1<<AW)-1];
	logic [31:0] rdata_q;

	if (AW < 1 || AW > 12) begin : g_chk
		$error("abr_table_mem: AW out of range");
	end

	// storage is left unreset, the host loads every entry it uses
	always_ff @(posedge clock) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata_q <= mem[tbl.addr];
	end

	assign tbl.nomLen = rdata_q[abr_pkg::TBL_NOM +: 16];
	assign tbl.maxLen = rdata_q[abr_pkg::TBL_MAX +: 16];
endmodule

// *** design/abr_bit_timer.sv ***
// down counter on sample ticks that pulses when a loaded length runs out
`timescale 1ns/1ps
module abr_bit_timer #(
	parameter int W = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic load,
	input wire logic [W-1:0] value,
	output logic expire
);
	logic [W-1:0] count_q, count_d;
	logic expire_q, expire_d;

	if (W < 2) begin : g_chk
		$error("abr_bit_timer: W too small");
	end

	// a zero load parks the timer; callers clamp lengths to at least one
	always_comb begin
		count_d = count_q;
		expire_d = 1'b0;
		if (load) begin
			count_d = value;
		end else if (tick && count_q != '0) begin
			count_d = count_q - 1'b1;
			expire_d = (count_q == W'(1));
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= '0;
			expire_q <= 1'b0;
		end else begin
			count_q <= count_d;
			expire_q <= expire_d;
		end
	end

	assign expire = expire_q;
endmodule

// *** design/abr_autobaud.sv ***
// autobaud rate detector: apb registers, start-bit measurement, assembly, echo
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/1ps
module abr_autobaud #(
	parameter int LEN_W = 16,
	parameter int TBL_AW = 8,
	parameter logic [4:0] CHANNEL = 5'h01
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic sampleTick,
	input wire logic rxLine,
	input wire logic carrierDetect,
	output logic txLine,
	output logic ctrlCharEvent,
	output logic bufWrEn,
	output logic [31:0] bufAddr,
	output logic [7:0] bufData
);
	if (LEN_W < 4 || LEN_W > 16 || TBL_AW < 1 || TBL_AW > 8) begin : g_chk
		$error("abr_autobaud: unsupported parameter values");
	end

	function automatic logic charHit(input logic [7:0] c, input logic [15:0] m);
		charHit = (c == m[7:0]) || (c == m[15:8]);
	endfunction

	function automatic logic [LEN_W-1:0] halfLen(input logic [15:0] n);
		logic [LEN_W-1:0] h;
		h = LEN_W'(n >> 1);
		halfLen = (h == '0) ? LEN_W'(1) : h;
	endfunction

	abr_tbl_if #(.AW(TBL_AW)) tbl();

	// apb side registers
	logic [31:0] ctrl_q, ctrl_d, sync_q, sync_d, table_q, table_d, match_q, match_d;
	logic [31:0] bufBase_q, bufBase_d, mask_q, mask_d, event_q, event_d, tblWa_q, tblWa_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d, pslverr_q, pslverr_d;
	logic wrStb, huntCmd, tblWe, known;
	logic [31:0] rdMux;
	// detector registers
	abr_pkg::abr_state_t state_q, state_d;
	logic [7:0] entry_q, entry_d, char_q, char_d, ctlChar_q, ctlChar_d, txChar_q, txChar_d;
	logic [LEN_W-1:0] startLen_q, startLen_d;
	logic [15:0] maxBit_q, maxBit_d, nomStart_q, nomStart_d;
	logic [3:0] bitCnt_q, bitCnt_d, txCnt_q, txCnt_d;
	logic [2:0] status_q, status_d;
	logic hit_q, hit_d, frame_q, frame_d, txBusy_q, txBusy_d, txPend_q, txPend_d;
	logic [31:0] bufCnt_q, bufCnt_d, lastPtr_q, lastPtr_d, bufAddr_q, bufAddr_d;
	logic [7:0] bufData_q, bufData_d;
	logic bufWrEn_q, bufWrEn_d, txLine_q, txLine_d, evOut_q, evOut_d;
	logic [31:0] evSet;
	logic rxLoad, rxExpire, txLoad, txExpire, echoAuto, echoSoft;
	logic [LEN_W-1:0] rxLoadVal;

	assign wrStb = psel && penable && pready_q && pwrite;
	assign tblWe = wrStb && paddr == abr_pkg::OFF_TBLDATA;
	// hunt command: opcode field 11 and our channel number
	assign huntCmd = wrStb && paddr == abr_pkg::OFF_CMD
		&& pwdata[abr_pkg::CMD_OPC +: 2] == abr_pkg::CMD_HUNT
		&& pwdata[abr_pkg::CMD_CH_W-1:0] == CHANNEL;
	// table address is the slot pointer plus the entry being tried
	assign tbl.addr = TBL_AW'(table_q[7:0] + entry_q);
	assign echoAuto = ctrl_q[abr_pkg::CTRL_LOOP +: 2] == abr_pkg::LOOP_ECHO && carrierDetect
		&& !ctrl_q[abr_pkg::CTRL_TXEN];
	assign echoSoft = sync_q[15:0] == abr_pkg::SYNC_ECHO && ctrl_q[abr_pkg::CTRL_TXEN];

	abr_table_mem #(.AW(TBL_AW)) u_mem (
		.clock(clock),
		.we(tblWe),
		.waddr(tblWa_q[TBL_AW-1:0]),
		.wdata(pwdata),
		.tbl(tbl.mem)
	);

	abr_bit_timer #(.W(LEN_W)) u_rxTimer (
		.clock(clock),
		.rst_n(rst_n),
		.tick(sampleTick),
		.load(rxLoad),
		.value(rxLoadVal),
		.expire(rxExpire)
	);

	abr_bit_timer #(.W(LEN_W)) u_txTimer (
		.clock(clock),
		.rst_n(rst_n),
		.tick(sampleTick),
		.load(txLoad),
		.value(halfLen(nomStart_q) + halfLen(nomStart_q)),
		.expire(txExpire)
	);

	// readback mux; unmapped addresses read zero and flag an error
	always_comb begin
		known = 1'b1;
		case (paddr)
			abr_pkg::OFF_CTRL: rdMux = ctrl_q;
			abr_pkg::OFF_CMD: rdMux = abr_pkg::RST_ZERO;
			abr_pkg::OFF_SYNC: rdMux = sync_q;
			abr_pkg::OFF_TABLE: rdMux = table_q;
			abr_pkg::OFF_MATCH: rdMux = match_q;
			abr_pkg::OFF_BUFPTR: rdMux = bufBase_q;
			abr_pkg::OFF_CTLCHAR: rdMux = {24'h000000, ctlChar_q};
			abr_pkg::OFF_STATUS: rdMux = {29'h00000000, status_q};
			abr_pkg::OFF_EVENT: rdMux = event_q;
			abr_pkg::OFF_MASK: rdMux = mask_q;
			abr_pkg::OFF_NOMSTART: rdMux = {16'h0000, nomStart_q};
			abr_pkg::OFF_MAXBIT: rdMux = {16'h0000, maxBit_q};
			abr_pkg::OFF_LASTPTR: rdMux = lastPtr_q;
			abr_pkg::OFF_TBLDATA: rdMux = abr_pkg::RST_ZERO;
			abr_pkg::OFF_TBLADDR: rdMux = tblWa_q;
			default: begin
				rdMux = abr_pkg::RST_ZERO;
				known = 1'b0;
			end
		endcase
	end

	// apb slave: one wait state, writes land at the completing edge
	always_comb begin
		ctrl_d = ctrl_q;
		sync_d = sync_q;
		table_d = table_q;
		match_d = match_q;
		bufBase_d = bufBase_q;
		mask_d = mask_q;
		tblWa_d = tblWa_q;
		event_d = event_q;
		pready_d = psel && penable && !pready_q;
		prdata_d = pready_d ? rdMux : abr_pkg::RST_ZERO;
		pslverr_d = pready_d && !known;
		if (wrStb) begin
			case (paddr)
				abr_pkg::OFF_CTRL: ctrl_d = {28'h0000000, pwdata[3:0]};
				abr_pkg::OFF_SYNC: sync_d = {16'h0000, pwdata[15:0]};
				abr_pkg::OFF_TABLE: table_d = {16'h0000, pwdata[15:0]};
				abr_pkg::OFF_MATCH: match_d = {16'h0000, pwdata[15:0]};
				abr_pkg::OFF_BUFPTR: bufBase_d = pwdata;
				abr_pkg::OFF_MASK: mask_d = {24'h000000, pwdata[7:0]};
				abr_pkg::OFF_TBLADDR: tblWa_d = {24'h000000, pwdata[7:0]};
				abr_pkg::OFF_EVENT: event_d = event_q & ~{24'h000000, pwdata[7:0]};
				default: ;
			endcase
		end
		// set wins over a write-one clear in the same cycle
		event_d = event_d | evSet;
	end

	// detector: hunt, start measurement, assembly, compare, software echo
	always_comb begin
		state_d = state_q;
		entry_d = entry_q;
		startLen_d = startLen_q;
		maxBit_d = maxBit_q;
		nomStart_d = nomStart_q;
		bitCnt_d = bitCnt_q;
		char_d = char_q;
		frame_d = frame_q;
		hit_d = hit_q;
		ctlChar_d = ctlChar_q;
		status_d = status_q;
		bufCnt_d = bufCnt_q;
		lastPtr_d = lastPtr_q;
		bufAddr_d = bufAddr_q;
		bufData_d = bufData_q;
		bufWrEn_d = 1'b0;
		txChar_d = txChar_q;
		txCnt_d = txCnt_q;
		txBusy_d = txBusy_q;
		txPend_d = txPend_q;
		evSet = abr_pkg::RST_ZERO;
		rxLoad = 1'b0;
		rxLoadVal = halfLen(nomStart_q);
		txLoad = 1'b0;
		case (state_q)
			abr_pkg::ABR_IDLE: ;
			abr_pkg::ABR_FETCH: state_d = abr_pkg::ABR_LATCH;
			abr_pkg::ABR_LATCH: begin
				maxBit_d = tbl.maxLen;
				nomStart_d = tbl.nomLen;
				state_d = (startLen_q == '0) ? abr_pkg::ABR_ARM : abr_pkg::ABR_START;
			end
			// wait for an idle high line so a half-seen character is ignored
			abr_pkg::ABR_ARM: begin
				if (sampleTick && rxLine) begin
					state_d = abr_pkg::ABR_HUNT;
				end
			end
			abr_pkg::ABR_HUNT: begin
				if (hit_q) begin
					// rate known: skip the start bit and land on the centre of bit 0,
					// so even characters need no start measurement; sync may be echo
					if (sampleTick && !rxLine && ctrl_q[abr_pkg::CTRL_RXEN]) begin
						rxLoad = 1'b1;
						rxLoadVal = LEN_W'(nomStart_q) + halfLen(nomStart_q);
						bitCnt_d = 4'h0;
						char_d = 8'h00;
						state_d = abr_pkg::ABR_ASSEMBLE;
					end
				end else if (sampleTick && !rxLine && ctrl_q[abr_pkg::CTRL_RXEN]
					&& sync_q[15:0] == abr_pkg::SYNC_START) begin
					startLen_d = LEN_W'(1);
					state_d = abr_pkg::ABR_START;
				end
			end
			abr_pkg::ABR_START: begin
				if (sampleTick && !rxLine) begin
					startLen_d = startLen_q + 1'b1;
				end else if (sampleTick) begin
					// first data bit is a one: start bit over, sample at centres
					rxLoad = 1'b1;
					bitCnt_d = 4'h0;
					char_d = 8'h00;
					state_d = abr_pkg::ABR_ASSEMBLE;
				end else if (16'(startLen_q) > maxBit_q) begin
					// too long for this rate: step to the next slower entry
					entry_d = entry_q + 8'h01;
					if (entry_d >= table_q[15:8]) begin
						entry_d = 8'h00;
						startLen_d = '0;
					end
					state_d = abr_pkg::ABR_FETCH;
				end
			end
			abr_pkg::ABR_ASSEMBLE: begin
				if (rxExpire) begin
					rxLoad = 1'b1;
					rxLoadVal = LEN_W'(nomStart_q);
					if (nomStart_q == 16'h0000) begin
						rxLoadVal = LEN_W'(1);
					end
					if (bitCnt_q < 4'(abr_pkg::CHAR_BITS)) begin
						char_d = {rxLine, char_q[7:1]};
						bitCnt_d = bitCnt_q + 4'h1;
					end else begin
						frame_d = !rxLine;
						state_d = abr_pkg::ABR_CHECK;
					end
				end
			end
			abr_pkg::ABR_CHECK: begin
				if (hit_q || charHit(char_q, match_q[15:0])) begin
					hit_d = 1'b1;
					ctlChar_d = char_q;
					status_d[abr_pkg::ST_M1] = char_q == match_q[7:0];
					status_d[abr_pkg::ST_M2] = char_q == match_q[15:8];
					status_d[abr_pkg::ST_FRAME] = frame_q;
					evSet[abr_pkg::EV_CTLCHAR] = 1'b1;
					bufWrEn_d = 1'b1;
					bufAddr_d = bufBase_q + bufCnt_q;
					bufData_d = char_q;
					lastPtr_d = bufBase_q + bufCnt_q;
					bufCnt_d = bufCnt_q + 32'h0000_0001;
					txPend_d = echoSoft;
					txChar_d = char_q;
					state_d = abr_pkg::ABR_ARM;
				end else begin
					// silent restart from the fastest entry
					entry_d = 8'h00;
					startLen_d = '0;
					state_d = abr_pkg::ABR_FETCH;
				end
			end
			default: state_d = abr_pkg::ABR_IDLE;
		endcase
		// software echo serialiser: start bit, eight data bits, stop bit
		if (!txBusy_q && txPend_q) begin
			txBusy_d = 1'b1;
			txPend_d = 1'b0;
			txCnt_d = 4'h0;
			txLoad = 1'b1;
		end else if (txBusy_q && txExpire) begin
			txLoad = 1'b1;
			txCnt_d = txCnt_q + 4'h1;
			if (txCnt_q == 4'(abr_pkg::TX_BITS - 1)) begin
				txBusy_d = 1'b0;
				evSet[abr_pkg::EV_TX] = 1'b1;
			end
		end
		if (huntCmd) begin
			entry_d = 8'h00;
			startLen_d = '0;
			hit_d = 1'b0;
			bufCnt_d = abr_pkg::RST_ZERO;
			state_d = abr_pkg::ABR_FETCH;
		end
	end

	// line driver and event output
	always_comb begin
		txLine_d = 1'b1;
		if (echoAuto) begin
			txLine_d = rxLine;
		end else if (txBusy_q) begin
			txLine_d = (txCnt_q == 4'h0) ? 1'b0
				: (txCnt_q > 4'(abr_pkg::CHAR_BITS)) ? 1'b1 : txChar_q[3'(txCnt_q - 4'h1)];
		end
		evOut_d = |(event_d & mask_q);
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= abr_pkg::RST_ZERO;
			sync_q <= abr_pkg::RST_ZERO;
			table_q <= abr_pkg::RST_ZERO;
			match_q <= abr_pkg::RST_ZERO;
			bufBase_q <= abr_pkg::RST_ZERO;
			mask_q <= abr_pkg::RST_ZERO;
			tblWa_q <= abr_pkg::RST_ZERO;
			event_q <= abr_pkg::RST_ZERO;
			prdata_q <= abr_pkg::RST_ZERO;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			state_q <= abr_pkg::ABR_IDLE;
			entry_q <= 8'h00;
			startLen_q <= '0;
			maxBit_q <= 16'h0000;
			nomStart_q <= 16'h0000;
			bitCnt_q <= 4'h0;
			char_q <= 8'h00;
			frame_q <= 1'b0;
			hit_q <= 1'b0;
			ctlChar_q <= 8'h00;
			status_q <= 3'h0;
			bufCnt_q <= abr_pkg::RST_ZERO;
			lastPtr_q <= abr_pkg::RST_ZERO;
			bufAddr_q <= abr_pkg::RST_ZERO;
			bufData_q <= 8'h00;
			bufWrEn_q <= 1'b0;
			txChar_q <= 8'h00;
			txCnt_q <= 4'h0;
			txBusy_q <= 1'b0;
			txPend_q <= 1'b0;
			txLine_q <= 1'b1;
			evOut_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			sync_q <= sync_d;
			table_q <= table_d;
			match_q <= match_d;
			bufBase_q <= bufBase_d;
			mask_q <= mask_d;
			tblWa_q <= tblWa_d;
			event_q <= event_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			state_q <= state_d;
			entry_q <= entry_d;
			startLen_q <= startLen_d;
			maxBit_q <= maxBit_d;
			nomStart_q <= nomStart_d;
			bitCnt_q <= bitCnt_d;
			char_q <= char_d;
			frame_q <= frame_d;
			hit_q <= hit_d;
			ctlChar_q <= ctlChar_d;
			status_q <= status_d;
			bufCnt_q <= bufCnt_d;
			lastPtr_q <= lastPtr_d;
			bufAddr_q <= bufAddr_d;
			bufData_q <= bufData_d;
			bufWrEn_q <= bufWrEn_d;
			txChar_q <= txChar_d;
			txCnt_q <= txCnt_d;
			txBusy_q <= txBusy_d;
			txPend_q <= txPend_d;
			txLine_q <= txLine_d;
			evOut_q <= evOut_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign txLine = txLine_q;
	assign ctrlCharEvent = evOut_q;
	assign bufWrEn = bufWrEn_q;
	assign bufAddr = bufAddr_q;
	assign bufData = bufData_q;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_fetch;
		state_q == abr_pkg::ABR_FETCH ##1 state_q == abr_pkg::ABR_LATCH;
	endsequence
	property p_tbl_addr;
		state_q == abr_pkg::ABR_FETCH |-> entry_q < table_q[15:8] || table_q[15:8] == 8'h00;
	endproperty
	a_tbl_addr: assert property (p_tbl_addr) else $error("entry outside table");
	property p_latch;
		s_fetch |=> maxBit_q == $past(tbl.maxLen) && nomStart_q == $past(tbl.nomLen);
	endproperty
	a_latch: assert property (p_latch) else $error("entry not latched");
	property p_count;
		state_q == abr_pkg::ABR_START && sampleTick && !rxLine && !huntCmd
			|=> startLen_q == $past(startLen_q) + 1'b1;
	endproperty
	a_count: assert property (p_count) else $error("start length not counted");
	property p_advance;
		state_q == abr_pkg::ABR_START && !sampleTick && !huntCmd
			&& 16'(startLen_q) > maxBit_q && entry_q + 8'h01 < table_q[15:8]
			|=> entry_q == $past(entry_q) + 8'h01 ##2 state_q == abr_pkg::ABR_START;
	endproperty
	a_advance: assert property (p_advance) else $error("no step to slower entry");
	property p_stop;
		state_q == abr_pkg::ABR_ASSEMBLE && rxExpire && bitCnt_q == 4'h8 && !huntCmd
			|=> state_q == abr_pkg::ABR_CHECK && frame_q == !$past(rxLine);
	endproperty
	a_stop: assert property (p_stop) else $error("stop bit mishandled");
	property p_miss;
		state_q == abr_pkg::ABR_CHECK && !hit_q && !charHit(char_q, match_q[15:0]) && !huntCmd
			|=> state_q == abr_pkg::ABR_FETCH && !bufWrEn_q && $stable(ctlChar_q);
	endproperty
	a_miss: assert property (p_miss) else $error("mismatch not silent");
	property p_match;
		state_q == abr_pkg::ABR_CHECK && charHit(char_q, match_q[15:0])
			|=> ctlChar_q == $past(char_q) && event_q[abr_pkg::EV_CTLCHAR] && bufWrEn_q;
	endproperty
	a_match: assert property (p_match) else $error("match not reported");
	property p_after;
		state_q == abr_pkg::ABR_CHECK && hit_q |=> bufWrEn_q && bufData_q == $past(char_q);
	endproperty
	a_after: assert property (p_after) else $error("later character not stored");
	property p_last;
		bufWrEn_q |-> lastPtr_q == bufAddr_q
			&& bufAddr_q == bufBase_q + bufCnt_q - 32'h0000_0001;
	endproperty
	a_last: assert property (p_last) else $error("last pointer stale");
	property p_echo;
		echoAuto |=> txLine_q == $past(rxLine);
	endproperty
	a_echo: assert property (p_echo) else $error("auto echo broken");
endmodule

// *** tb/abr_terminal.sv ***
// remote terminal model that sends asynchronous characters on the receive line
`timescale 1ns/1ps
module abr_terminal #(
	parameter int BIT_TICKS = 16
) (
	input wire logic clock,
	input wire logic sampleTick,
	output logic rxLine
);
	// the line idles high between frames, as a real terminal leaves it
	initial begin
		rxLine = 1'b1;
	end

	// wait for a number of sampling strobes
	task automatic wait_ticks(input int n);
		repeat (n) begin
			@(posedge clock);
			while (sampleTick !== 1'b1) @(posedge clock);
		end
	endtask

	// start bit, eight data bits lsb first, one stop bit, then idle
	task automatic send(input logic [7:0] ch, input logic stopBit);
		rxLine <= 1'b0;
		wait_ticks(BIT_TICKS);
		for (int i = 0; i < 8; i++) begin
			rxLine <= ch[i];
			wait_ticks(BIT_TICKS);
		end
		rxLine <= stopBit; // stop low only where a framing fault is wanted
		wait_ticks(BIT_TICKS);
		rxLine <= 1'b1;
		wait_ticks(2 * BIT_TICKS);
	endtask
endmodule

// *** tb/abr_autobaud_bench.sv ***
// self-checking bench for the autobaud rate detector
`timescale 1ns/1ps
module abr_autobaud_bench;
	logic clock, rst_n, psel, penable, pwrite, pready, pslverr, sampleTick, rxLine;
	logic carrierDetect, txLine, ctrlCharEvent, bufWrEn, lastErr, rxPrev, echoOn;
	logic [7:0] paddr, bufData, echoChar;
	logic [31:0] pwdata, prdata, bufAddr, rdVal;
	logic [1:0] tickCnt;
	int n_errors, checks, nStored, echoBad;

	abr_autobaud i_abr_autobaud (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sampleTick(sampleTick), .rxLine(rxLine),
		.carrierDetect(carrierDetect), .txLine(txLine), .ctrlCharEvent(ctrlCharEvent),
		.bufWrEn(bufWrEn), .bufAddr(bufAddr), .bufData(bufData));
	abr_terminal i_abr_terminal (.clock(clock), .sampleTick(sampleTick), .rxLine(rxLine));

	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// sampling strobe every fourth clock, so a bit of 16 ticks spans 64 clocks
	always @(posedge clock) begin
		tickCnt <= tickCnt + 2'h1;
		sampleTick <= (tickCnt == 2'h3);
	end

	// count stores and watch the echo path against the line one cycle late
	always @(posedge clock) begin
		rxPrev <= rxLine;
		if (bufWrEn === 1'b1) nStored++;
	end
	always @(negedge clock) begin
		if (echoOn ? (txLine !== rxPrev) : (txLine !== 1'b1)) echoBad++;
	end

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one apb transfer; setup, then access held until pready is sampled high
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		// no cycle count assumed: only the watchdog ends a wait that never completes
		do begin
			@(posedge clock);
		end while (pready !== 1'b1);
		rdVal = prdata;
		lastErr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string name);
		apb(a, 1'b0, 32'h0000_0000);
		chk(name, rdVal & m, e);
	endtask

	task automatic give_verdict();
		if (n_errors == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// a hung handshake or a stuck line ends the run here
	initial begin
		#400000;
		n_errors++;
		give_verdict();
	end

	initial begin
		{psel, penable, pwrite, carrierDetect, echoOn} = 5'h00;
		{paddr, pwdata, tickCnt, n_errors, checks, nStored, echoBad} = '0;
		rst_n = 1'b0;
		repeat (6) @(posedge clock);
		rst_n <= 1'b1;
		chk("ctrlCharEvent", {31'h0, ctrlCharEvent}, 32'h0000_0000);
		rd(abr_pkg::OFF_EVENT, 32'hFFFF_FFFF, 32'h0000_0000, "event reset");
		rd(8'h3C, 32'hFFFF_FFFF, 32'h0000_0000, "unmapped read");
		chk("pslverr", {31'h0, lastErr}, 32'h0000_0001);
		// two entries: fast rate max 10 nom 8, slower rate max 20 nom 16
		apb(abr_pkg::OFF_TBLADDR, 1'b1, 32'h0000_0000);
		apb(abr_pkg::OFF_TBLDATA, 1'b1, 32'h000A_0008);
		apb(abr_pkg::OFF_TBLADDR, 1'b1, 32'h0000_0001);
		apb(abr_pkg::OFF_TBLDATA, 1'b1, 32'h0014_0010);
		apb(abr_pkg::OFF_TABLE, 1'b1, 32'h0000_0200);
		apb(abr_pkg::OFF_MATCH, 1'b1, 32'h0000_4161);
		apb(abr_pkg::OFF_BUFPTR, 1'b1, 32'h0000_1000);
		apb(abr_pkg::OFF_SYNC, 1'b1, 32'h0000_7FFF);
		apb(abr_pkg::OFF_CMD, 1'b1, 32'h0000_0062);
		apb(abr_pkg::OFF_CTRL, 1'b1, 32'h0000_0001);
		i_abr_terminal.send(8'h61, 1'b1);
		chk("stores other channel", nStored, 32'h0000_0000);
		apb(abr_pkg::OFF_CMD, 1'b1, 32'h0000_0061);
		i_abr_terminal.send(8'h33, 1'b1);
		chk("stores mismatch", nStored, 32'h0000_0000);
		rd(abr_pkg::OFF_EVENT, 32'hFFFF_FFFF, 32'h0000_0000, "event mismatch");
		i_abr_terminal.send(8'h61, 1'b1);
		chk("stores match", nStored, 32'h0000_0001);
		chk("bufAddr", bufAddr, 32'h0000_1000);
		chk("bufData", {24'h0, bufData}, 32'h0000_0061);
		rd(abr_pkg::OFF_CTLCHAR, 32'h0000_00FF, 32'h0000_0061, "ctlchar");
		rd(abr_pkg::OFF_STATUS, 32'h0000_0007, 32'h0000_0001, "status");
		rd(abr_pkg::OFF_EVENT, 32'hFFFF_FFFF, 32'h0000_0008, "event");
		chk("masked event", {31'h0, ctrlCharEvent}, 32'h0000_0000);
		rd(abr_pkg::OFF_NOMSTART, 32'h0000_FFFF, 32'h0000_0010, "nomstart");
		rd(abr_pkg::OFF_LASTPTR, 32'hFFFF_FFFF, 32'h0000_1000, "lastptr");
		apb(abr_pkg::OFF_MASK, 1'b1, 32'h0000_0008);
		repeat (3) @(negedge clock);
		chk("unmasked event", {31'h0, ctrlCharEvent}, 32'h0000_0001);
		apb(abr_pkg::OFF_EVENT, 1'b1, 32'h0000_0008);
		repeat (3) @(negedge clock);
		chk("cleared event", {31'h0, ctrlCharEvent}, 32'h0000_0000);
		// even character after the first match, stop bit held low
		i_abr_terminal.send(8'h42, 1'b0);
		chk("stores next", nStored, 32'h0000_0002);
		chk("bufAddr next", bufAddr, 32'h0000_1001);
		chk("bufData next", {24'h0, bufData}, 32'h0000_0042);
		rd(abr_pkg::OFF_STATUS, 32'h0000_0004, 32'h0000_0004, "framing");
		rd(abr_pkg::OFF_EVENT, 32'hFFFF_FFFF, 32'h0000_0008, "event next");
		rd(abr_pkg::OFF_LASTPTR, 32'hFFFF_FFFF, 32'h0000_1001, "lastptr next");
		// auto echo: diagnostic 10, carrier detect, transmitter off
		carrierDetect <= 1'b1;
		apb(abr_pkg::OFF_CTRL, 1'b1, 32'h0000_0009);
		repeat (2) @(posedge clock);
		echoOn = 1'b1;
		i_abr_terminal.send(8'h45, 1'b1);
		chk("echo mismatches", echoBad, 32'h0000_0000);
		// software echo: sync FFFF, transmitter on; catch the echoed frame at bit centres
		apb(abr_pkg::OFF_SYNC, 1'b1, 32'h0000_FFFF);
		apb(abr_pkg::OFF_CTRL, 1'b1, 32'h0000_0003);
		fork
			i_abr_terminal.send(8'h57, 1'b1);
			begin
				@(negedge txLine);
				repeat (32) @(posedge clock);
				for (int i = 0; i < 8; i++) begin
					repeat (64) @(posedge clock);
					echoChar[i] = txLine;
				end
			end
		join
		chk("soft echo", {24'h0, echoChar}, 32'h0000_0057);
		repeat (160) @(posedge clock);
		rd(abr_pkg::OFF_EVENT, 32'h0000_0002, 32'h0000_0002, "tx event");
		// end of message: back to hunt settings, then a fresh hunt compares again
		apb(abr_pkg::OFF_SYNC, 1'b1, 32'h0000_7FFF);
		apb(abr_pkg::OFF_CTRL, 1'b1, 32'h0000_0001);
		apb(abr_pkg::OFF_CMD, 1'b1, 32'h0000_0061);
		i_abr_terminal.send(8'h33, 1'b1);
		chk("stores rehunt", nStored, 32'h0000_0004);
		give_verdict();
	end
endmodule
